// File: pkg/cac_pkg.sv
// charge accumulator counter: shared offsets, field positions, reset values and carriers
// assumes a single core clock; all serial and converter pins arrive asynchronously
package cac_pkg;

   // ****************************************
   // serial port
   // ****************************************
   localparam logic [6:0]  DEV_ADDR       = 7'h5A;   // arbitrary bus address
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0]  ACK_DONE       = 4'h9;

   // ****************************************
   // register offsets and fields
   // ****************************************
   localparam logic [7:0]  OFF_ALERT_EN   = 8'h0D;
   localparam logic [7:0]  OFF_LOW_LIMIT  = 8'h10;
   localparam logic [7:0]  OFF_HIGH_LIMIT = 8'h11;
   localparam logic [7:0]  OFF_RATIO      = 8'h12;
   localparam logic [7:0]  OFF_ACCUM      = 8'h13;
   localparam logic [7:0]  OFF_CONFIG     = 8'h14;
   localparam logic [7:0]  OFF_FLAGS      = 8'h1F;
   localparam int          BIT_LOW_EN     = 13;
   localparam int          BIT_HIGH_EN    = 12;
   localparam int          BIT_COUNT_EN   = 2;
   localparam int          BIT_LOW_FLAG   = 1;
   localparam int          BIT_HIGH_FLAG  = 0;

   // ****************************************
   // reset values and accumulator limits
   // ****************************************
   localparam logic [15:0] RST_RATIO      = 16'h0200;
   localparam logic [15:0] RST_LOW_LIMIT  = 16'h0000;
   localparam logic [15:0] RST_HIGH_LIMIT = 16'hFFFF;
   localparam logic [15:0] RST_ACCUM      = 16'h0000;
   localparam logic [15:0] ACCUM_MAX      = 16'hFFFF;
   localparam logic [15:0] ACCUM_MIN      = 16'h0000;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic        tick;    // converter tick, one rising edge per ramp reversal
      logic        sw;      // converter switch state
      logic        ramp;    // converter ramp direction
   } cac_conv_t;

   typedef struct packed {
      logic        wr;      // one-cycle write strobe
      logic [7:0]  addr;    // command code selects the register
      logic [15:0] data;    // word, low byte sent first
   } cac_wr_t;

endpackage : cac_pkg

// File: hdl/cac_serial_slave.sv
// serial word-register slave: address, command, two data bytes, low byte first
// assumes scl and sda are asynchronous pins; read data is served from rd_data by command
`timescale 1ns/100ps
module cac_serial_slave (
   input  wire logic           core_clk,  // core clock
   input  wire logic           rst,       // synchronous reset
   input  wire logic           ce,        // clock enable
   input  wire logic           scl_i,     // serial clock pin
   input  wire logic           sda_i,     // serial data pin level
   output logic                sda_oe,    // high pulls data low
   output cac_pkg::cac_wr_t    wr_req,    // register write strobe
   output logic [7:0]          rd_addr,   // command code for reads
   input  wire logic [15:0]    rd_data    // word at rd_addr
);

   typedef enum logic [2:0] {CAC_IDLE, CAC_ADDR, CAC_CMD, CAC_WLO, CAC_WHI, CAC_RD, CAC_IGN}
      cac_sst_t;

   logic [2:0]  scl_s, sda_s;             // [0],[1] synchroniser, [2] previous level
   cac_sst_t    st, next_st;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  sh, next_sh, lo, next_lo, cmd, next_cmd;
   logic [15:0] txs, next_txs;
   logic        ack, next_ack, next_oe;
   cac_pkg::cac_wr_t next_wr;
   logic        rise, fall, start, stop;
   logic [7:0]  byte_in;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // only the second stage and its delayed copy feed edge detection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else if (ce) begin
         scl_s <= {scl_s[1:0], scl_i};
         sda_s <= {sda_s[1:0], sda_i};
      end
   end

   assign rise    = scl_s[1] & ~scl_s[2];
   assign fall    = ~scl_s[1] & scl_s[2];
   assign start   = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign stop    = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   assign byte_in = {sh[6:0], sda_s[1]};
   assign rd_addr = cmd;

   // ****************************************
   // byte engine
   // ****************************************
   // next state of the protocol; a stop or new start always resyncs the engine
   always_comb begin
      next_st  = st;
      next_cnt = cnt;
      next_sh  = sh;
      next_lo  = lo;
      next_cmd = cmd;
      next_txs = txs;
      next_ack = ack;
      next_oe  = sda_oe;
      next_wr  = '{wr: 1'b0, addr: cmd, data: 16'h0000};
      if (start) begin
         next_st  = CAC_ADDR;
         next_cnt = 4'h0;
         next_oe  = 1'b0;
      end else if (stop) begin
         next_st  = CAC_IDLE;
         next_oe  = 1'b0;
      end else if (st != CAC_IDLE && rise) begin
         if (cnt < cac_pkg::BITS_PER_BYTE) begin
            next_sh  = byte_in;
            next_cnt = cnt + 4'h1;
         end else begin
            next_cnt = cac_pkg::ACK_DONE;
            if (st == CAC_RD && sda_s[1]) next_st = CAC_IDLE;  // host nack ends the read
         end
         if (cnt == cac_pkg::BITS_PER_BYTE - 4'h1) begin
            next_ack = 1'b1;
            case (st)
               CAC_ADDR: begin
                  if (byte_in[7:1] != cac_pkg::DEV_ADDR) begin
                     next_ack = 1'b0;
                     next_st  = CAC_IGN;
                  end else if (byte_in[0]) begin
                     next_st  = CAC_RD;
                     next_txs = {rd_data[7:0], rd_data[15:8]};
                  end else begin
                     next_st  = CAC_CMD;
                  end
               end
               CAC_CMD: begin
                  next_cmd = byte_in;
                  next_st  = CAC_WLO;
               end
               CAC_WLO: begin
                  next_lo = byte_in;
                  next_st = CAC_WHI;
               end
               CAC_WHI: begin
                  next_wr = '{wr: 1'b1, addr: cmd, data: {byte_in, lo}};
                  next_st = CAC_IGN;
               end
               default: next_ack = 1'b0;            // reads and surplus bytes
            endcase
         end
      end else if (st != CAC_IDLE && fall) begin
         next_oe = 1'b0;
         if (cnt == cac_pkg::ACK_DONE) next_cnt = 4'h0;
         if (cnt == cac_pkg::BITS_PER_BYTE) begin
            next_oe = ack;
         end else if (st == CAC_RD && (cnt == cac_pkg::ACK_DONE ||
                                       cnt < cac_pkg::BITS_PER_BYTE)) begin
            next_oe  = ~txs[15];                     // drive low for a zero bit
            next_txs = {txs[14:0], 1'b1};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st     <= CAC_IDLE;
         cnt    <= 4'h0;
         sh     <= 8'h00;
         lo     <= 8'h00;
         cmd    <= 8'h00;
         txs    <= 16'hFFFF;
         ack    <= 1'b0;
         sda_oe <= 1'b0;
         wr_req <= '0;
      end else if (ce) begin
         st     <= next_st;
         cnt    <= next_cnt;
         sh     <= next_sh;
         lo     <= next_lo;
         cmd    <= next_cmd;
         txs    <= next_txs;
         ack    <= next_ack;
         sda_oe <= next_oe;
         wr_req <= next_wr;
      end
   end

endmodule : cac_serial_slave

// File: hdl/cac_top.sv
// charge accumulator counter: tick divider, saturating accumulator, trip alerts, registers
// assumes converter and serial pins are asynchronous; registers reached over the serial port
`timescale 1ns/100ps
module cac_top (
   input  wire logic              core_clk,  // 200 MHz core clock
   input  wire logic              rst,       // synchronous reset, active high
   input  wire logic              ce,        // clock enable, freezes all state
   input  wire cac_pkg::cac_conv_t conv,     // converter tick, switch, ramp
   input  wire logic              scl_i,     // serial clock pin
   input  wire logic              sda_i,     // serial data pin level
   output logic                   sda_o,     // serial data drive level
   output logic                   sda_oe,    // serial data pull-low enable
   output logic                   alert_o,   // alert drive level
   output logic                   alert_oe   // alert pull-low enable
);

   logic [2:0]       tick_s;                 // [0],[1] synchroniser, [2] previous
   logic [1:0]       sw_s, ramp_s;
   logic [15:0]      low_lim, next_low_lim, high_lim, next_high_lim;
   logic [15:0]      ratio, next_ratio, accum, next_accum;
   logic             cnt_en, next_cnt_en, low_en, next_low_en, high_en, next_high_en;
   logic             low_flag, next_low_flag, high_flag, next_high_flag, next_alert;
   logic signed [16:0] div, next_div;
   logic             tick_edge, up, ovf, unf;
   cac_pkg::cac_wr_t wr_req;
   logic [7:0]       rd_addr;
   logic [15:0]      rd_data;

   // decode shared by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   assign sda_o   = 1'b0;                    // open drain: only ever pulls low
   assign alert_o = 1'b0;

   // ****************************************
   // serial port
   // ****************************************
   cac_serial_slave cac_serial_slave_inst (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_oe   (sda_oe),
      .wr_req   (wr_req),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   // ****************************************
   // converter synchronisers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_s <= 3'h0;
         sw_s   <= 2'h0;
         ramp_s <= 2'h0;
      end else if (ce) begin
         tick_s <= {tick_s[1:0], conv.tick};
         sw_s   <= {sw_s[0], conv.sw};
         ramp_s <= {ramp_s[0], conv.ramp};
      end
   end

   assign tick_edge = tick_s[1] & ~tick_s[2];
   assign up        = sw_s[1] ^ ramp_s[1];

   // ****************************************
   // read mux
   // ****************************************
   // unmapped commands read as zero; any register may be read at any time
   always_comb begin
      rd_data = 16'h0000;
      if (hit(rd_addr, cac_pkg::OFF_ALERT_EN)) begin
         rd_data[cac_pkg::BIT_LOW_EN]  = low_en;
         rd_data[cac_pkg::BIT_HIGH_EN] = high_en;
      end
      if (hit(rd_addr, cac_pkg::OFF_LOW_LIMIT))  rd_data = low_lim;
      if (hit(rd_addr, cac_pkg::OFF_HIGH_LIMIT)) rd_data = high_lim;
      if (hit(rd_addr, cac_pkg::OFF_RATIO))      rd_data = ratio;
      if (hit(rd_addr, cac_pkg::OFF_ACCUM))      rd_data = accum;
      if (hit(rd_addr, cac_pkg::OFF_CONFIG))     rd_data[cac_pkg::BIT_COUNT_EN] = cnt_en;
      if (hit(rd_addr, cac_pkg::OFF_FLAGS)) begin
         rd_data[cac_pkg::BIT_LOW_FLAG]  = low_flag;
         rd_data[cac_pkg::BIT_HIGH_FLAG] = high_flag;
      end
   end

   // ****************************************
   // registers, divider, accumulator, alerts
   // ****************************************
   // a ratio of zero behaves as one: every tick overflows or underflows
   always_comb begin
      next_low_lim  = low_lim;
      next_high_lim = high_lim;
      next_ratio    = ratio;
      next_cnt_en   = cnt_en;
      next_low_en   = low_en;
      next_high_en  = high_en;
      next_div      = div;
      next_accum    = accum;
      ovf           = 1'b0;
      unf           = 1'b0;
      if (!cnt_en) begin
         next_div = 17'sh00000;
      end else if (tick_edge) begin
         if (up && div + 17'sh00001 >= $signed({1'b0, ratio})) begin
            ovf      = 1'b1;
            next_div = 17'sh00000;
         end else if (!up && div - 17'sh00001 <= -$signed({1'b0, ratio})) begin
            unf      = 1'b1;
            next_div = 17'sh00000;
         end else if (up) begin
            next_div = div + 17'sh00001;
         end else begin
            next_div = div - 17'sh00001;
         end
      end
      if (ovf && accum != cac_pkg::ACCUM_MAX) next_accum = accum + 16'h0001;
      if (unf && accum != cac_pkg::ACCUM_MIN) next_accum = accum - 16'h0001;
      if (wr_req.wr) begin
         if (hit(wr_req.addr, cac_pkg::OFF_LOW_LIMIT))  next_low_lim  = wr_req.data;
         if (hit(wr_req.addr, cac_pkg::OFF_HIGH_LIMIT)) next_high_lim = wr_req.data;
         if (hit(wr_req.addr, cac_pkg::OFF_RATIO))      next_ratio    = wr_req.data;
         if (hit(wr_req.addr, cac_pkg::OFF_ACCUM))      next_accum    = wr_req.data;
         if (hit(wr_req.addr, cac_pkg::OFF_CONFIG))
            next_cnt_en = wr_req.data[cac_pkg::BIT_COUNT_EN];
         if (hit(wr_req.addr, cac_pkg::OFF_ALERT_EN)) begin
            next_low_en  = wr_req.data[cac_pkg::BIT_LOW_EN];
            next_high_en = wr_req.data[cac_pkg::BIT_HIGH_EN];
         end
      end
   end

   // flags are sticky; writing a zero clears, a same-cycle trip still sets
   always_comb begin
      next_low_flag  = low_flag;
      next_high_flag = high_flag;
      if (wr_req.wr && hit(wr_req.addr, cac_pkg::OFF_FLAGS)) begin
         next_low_flag  = low_flag & wr_req.data[cac_pkg::BIT_LOW_FLAG];
         next_high_flag = high_flag & wr_req.data[cac_pkg::BIT_HIGH_FLAG];
      end
      if (low_en && accum < low_lim)   next_low_flag  = 1'b1;
      if (high_en && accum > high_lim) next_high_flag = 1'b1;
      next_alert = next_low_flag | next_high_flag;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         low_lim   <= cac_pkg::RST_LOW_LIMIT;
         high_lim  <= cac_pkg::RST_HIGH_LIMIT;
         ratio     <= cac_pkg::RST_RATIO;
         accum     <= cac_pkg::RST_ACCUM;
         cnt_en    <= 1'b0;
         low_en    <= 1'b0;
         high_en   <= 1'b0;
         div       <= 17'sh00000;
         low_flag  <= 1'b0;
         high_flag <= 1'b0;
         alert_oe  <= 1'b0;
      end else if (ce) begin
         low_lim   <= next_low_lim;
         high_lim  <= next_high_lim;
         ratio     <= next_ratio;
         accum     <= next_accum;
         cnt_en    <= next_cnt_en;
         low_en    <= next_low_en;
         high_en   <= next_high_en;
         div       <= next_div;
         low_flag  <= next_low_flag;
         high_flag <= next_high_flag;
         alert_oe  <= next_alert;
      end
   end

endmodule : cac_top

// File: bench/cac_top_monitor.sv
// checker for the charge accumulator counter, watching the top module's pins only
// assumes ce, converter and serial pins come from the bench; bound into cac_top below
`timescale 1ns/100ps
module cac_top_monitor (
   input wire logic               core_clk,  // core clock
   input wire logic               rst,       // synchronous reset
   input wire logic               ce,        // clock enable
   input wire cac_pkg::cac_conv_t conv,      // converter pins
   input wire logic               scl_i,     // serial clock pin
   input wire logic               sda_i,     // resolved data wire
   input wire logic               sda_o,     // data drive level
   input wire logic               sda_oe,    // data pull-low enable
   input wire logic               alert_o,   // alert drive level
   input wire logic               alert_oe   // alert pull-low enable
);
   // ****************************************
   // helper state
   // ****************************************
   logic quiet;       // serial clock untouched since reset, so no enable can be set
   logic next_quiet;

   // cleared by the first serial clock low
   always_comb begin
      next_quiet = quiet & scl_i;
      if (rst) begin
         next_quiet = 1'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      quiet <= next_quiet;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ****************************************
   // assertions
   // ****************************************
   a_sda_level: assert property (sda_o == 1'h0)
      else $error("data drive level is not low");
   a_alert_level: assert property (alert_o == 1'h0)
      else $error("alert drive level is not low");
   a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !alert_oe)
      else $error("pins driven after reset");
   // data only moves while the serial clock is low
   a_sda_change: assert property (!$past(rst) && $changed(sda_oe) |-> !$past(scl_i))
      else $error("data changed during clock high");
   a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe[*8])
      else $error("pulled data bit too short");
   // flags only clear through a host write
   a_alert_sticky: assert property (!$past(rst) && $fell(alert_oe) |-> $past(scl_i, 2))
      else $error("alert dropped without a host write");
   a_alert_gated: assert property (quiet |-> !alert_oe)
      else $error("alert raised with both enables clear");
   a_ce_freeze: assert property (!ce |=> $stable(sda_oe) && $stable(alert_oe))
      else $error("outputs moved while clock enable low");

   c_alert_up: cover property ($rose(alert_oe));
   c_alert_clear: cover property (!$past(rst) && $fell(alert_oe));
   c_ack: cover property ($rose(sda_oe));
endmodule : cac_top_monitor

bind cac_top cac_top_monitor cac_top_monitor_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
   .conv(conv), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .alert_o(alert_o), .alert_oe(alert_oe));

// File: bench/cac_host_model.sv
// host controller model on the serial port: word writes and word reads
// assumes the bench resolves the data wire from this pull and the device's pull
`timescale 1ns/100ps
module cac_host_model (
   input  wire logic core_clk,  // paces the serial bits
   input  wire logic sda_i,     // resolved data wire
   output logic      scl,       // serial clock, 160 ns period
   output logic      sda_pull   // high pulls data low
);
   initial begin
      scl = 1'h1;
      sda_pull = 1'h0;
   end

   // a quarter of the serial period is 8 core cycles
   task automatic waitq(input int n);
      repeat (8 * n) @(posedge core_clk);
   endtask : waitq

   // released bits read the device, sampled mid high phase where it is settled
   task automatic bit_io(input logic b, output logic seen);
      sda_pull <= ~b;
      waitq(1);
      scl <= 1'h1;
      waitq(1);
      @(negedge core_clk) seen = sda_i;
      waitq(1);
      scl <= 1'h0;
      waitq(1);
   endtask : bit_io

   // eight data bits, msb first, then the acknowledge slot
   task automatic byte_io(input logic [8:0] v, output logic [8:0] got);
      for (int i = 8; i >= 0; i--) bit_io(v[i], got[i]);
   endtask : byte_io

   task automatic start_c;
      sda_pull <= 1'h0;
      waitq(1);
      scl <= 1'h1;
      waitq(1);
      sda_pull <= 1'h1;
      waitq(1);
      scl <= 1'h0;
      waitq(1);
   endtask : start_c

   task automatic stop_c;
      sda_pull <= 1'h1;
      waitq(1);
      scl <= 1'h1;
      waitq(1);
      sda_pull <= 1'h0;
      waitq(2);
   endtask : stop_c

   // ack is high only when all four bytes were acknowledged
   task automatic write_word(input logic [6:0] dev, input logic [7:0] cmd,
                             input logic [15:0] d, output logic ack);
      logic [8:0] g0, g1, g2, g3;
      start_c;
      byte_io({dev, 1'h0, 1'h1}, g0);
      byte_io({cmd, 1'h1}, g1);
      byte_io({d[7:0], 1'h1}, g2);   // low byte first, whole word only
      byte_io({d[15:8], 1'h1}, g3);
      stop_c;
      ack = ~(g0[0] | g1[0] | g2[0] | g3[0]);
   endtask : write_word

   // acks the low byte and nacks the high byte to end the read
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
      logic [8:0] g0, lo, hi;
      start_c;
      byte_io({cac_pkg::DEV_ADDR, 1'h0, 1'h1}, g0);
      byte_io({cmd, 1'h1}, g0);
      start_c;
      byte_io({cac_pkg::DEV_ADDR, 1'h1, 1'h1}, g0);
      byte_io({8'hFF, 1'h0}, lo);
      byte_io({8'hFF, 1'h1}, hi);
      stop_c;
      d = {hi[8:1], lo[8:1]};
   endtask : read_word
endmodule : cac_host_model

// File: bench/cac_top_test.sv
// self-checking bench for the charge accumulator counter over its serial port
// assumes the host model drives the serial clock; data wire pulled up unless pulled low
`timescale 1ns/100ps
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", s, e, g); end end
module cac_top_test;
   logic               core_clk;
   logic               rst;
   logic               ce;
   cac_pkg::cac_conv_t conv;
   logic               scl;
   logic               sda_pull;
   logic               sda_oe;
   logic               alert_oe;
   wire logic          sda_wire;
   int                 mismatches;
   int                 num_checks;
   logic [15:0]        rdv;
   logic               ack;

   assign sda_wire = ~(sda_pull | sda_oe);  // open drain with pull-up

   cac_top cac_top_inst (.core_clk(core_clk), .rst(rst), .ce(ce), .conv(conv), .scl_i(scl),
      .sda_i(sda_wire), .sda_o(), .sda_oe(sda_oe), .alert_o(), .alert_oe(alert_oe));
   cac_host_model cac_host_model_inst (.core_clk(core_clk), .sda_i(sda_wire), .scl(scl),
      .sda_pull(sda_pull));

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      cac_host_model_inst.write_word(cac_pkg::DEV_ADDR, cmd, d, ack);
      `CHK("write ack", 1'h1, ack)
   endtask : wr

   task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] e);
      cac_host_model_inst.read_word(cmd, rdv);
      `CHK($sformatf("reg %h", cmd), e, rdv)
   endtask : rd_chk

   // n ticks; both switch and ramp pairings used for each sign
   task automatic ticks(input logic up, input int n);
      for (int i = 0; i < n; i++) begin
         conv.sw <= i[0];
         conv.ramp <= i[0] ^ up;
         repeat (4) @(posedge core_clk);
         conv.tick <= 1'h1;
         repeat (4) @(posedge core_clk);
         conv.tick <= 1'h0;
      end
      repeat (8) @(posedge core_clk);
   endtask : ticks

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   // a hang counts as a mismatch
   initial begin
      repeat (90000) @(posedge core_clk);
      mismatches++;
      give_verdict;
   end

   initial begin
      rst = 1'h1;
      ce = 1'h1;
      conv = '0;
      mismatches = 0;
      num_checks = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'h0;
      repeat (4) @(posedge core_clk);
      ce <= 1'h0;
      repeat (4) @(posedge core_clk);
      ce <= 1'h1;
      rd_chk(cac_pkg::OFF_LOW_LIMIT, 16'h0000);
      rd_chk(cac_pkg::OFF_HIGH_LIMIT, 16'hFFFF);
      // clock enable dropped across the release of a driven zero bit of the read
      fork
         rd_chk(cac_pkg::OFF_RATIO, 16'h0200);
         begin
            repeat (1176) @(posedge core_clk);
            ce <= 1'h0;
            repeat (8) @(posedge core_clk);
            ce <= 1'h1;
         end
      join
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0000);
      rd_chk(8'h20, 16'h0000);
      cac_host_model_inst.write_word(cac_pkg::DEV_ADDR ^ 7'h01, cac_pkg::OFF_ACCUM, 16'h1234, ack);
      `CHK("foreign ack", 1'h0, ack)
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0000);
      $display("test reset and access done");
      // counting stays off until enabled
      wr(cac_pkg::OFF_RATIO, 16'hFFFF);
      rd_chk(cac_pkg::OFF_RATIO, 16'hFFFF);
      wr(cac_pkg::OFF_RATIO, 16'h0001);
      ticks(1'h1, 3);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0000);
      wr(cac_pkg::OFF_RATIO, 16'h0003);
      wr(cac_pkg::OFF_CONFIG, 16'h0004);
      rd_chk(cac_pkg::OFF_CONFIG, 16'h0004);
      ticks(1'h1, 5);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0001);
      ticks(1'h1, 1);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0002);
      ticks(1'h0, 5);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0001);
      ticks(1'h0, 4);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0000);
      // a part-filled divider must restart from zero after a disable
      ticks(1'h1, 2);
      wr(cac_pkg::OFF_CONFIG, 16'h0000);
      ticks(1'h1, 2);
      wr(cac_pkg::OFF_CONFIG, 16'h0004);
      ticks(1'h1, 2);
      rd_chk(cac_pkg::OFF_ACCUM, 16'h0000);
      wr(cac_pkg::OFF_RATIO, 16'h0001);
      wr(cac_pkg::OFF_ACCUM, 16'hFFFE);
      ticks(1'h1, 3);
      rd_chk(cac_pkg::OFF_ACCUM, 16'hFFFF);
      $display("test counting done");
      wr(cac_pkg::OFF_HIGH_LIMIT, 16'hFFFE);
      `CHK("alert", 1'h0, alert_oe)
      wr(cac_pkg::OFF_ALERT_EN, 16'h1000);
      `CHK("alert", 1'h1, alert_oe)
      rd_chk(cac_pkg::OFF_FLAGS, 16'h0001);
      wr(cac_pkg::OFF_ALERT_EN, 16'h0000);
      wr(cac_pkg::OFF_FLAGS, 16'h0000);
      `CHK("alert", 1'h0, alert_oe)
      wr(cac_pkg::OFF_LOW_LIMIT, 16'h0010);
      wr(cac_pkg::OFF_ACCUM, 16'h0005);
      `CHK("alert", 1'h0, alert_oe)
      wr(cac_pkg::OFF_ALERT_EN, 16'h2000);
      `CHK("alert", 1'h1, alert_oe)
      rd_chk(cac_pkg::OFF_FLAGS, 16'h0002);
      rd_chk(cac_pkg::OFF_ALERT_EN, 16'h2000);
      // clearing while still below the low limit: the trip sets the flag again
      wr(cac_pkg::OFF_FLAGS, 16'h0000);
      `CHK("alert", 1'h1, alert_oe)
      $display("test alerts done");
      give_verdict;
   end
endmodule : cac_top_test
